/* File: design/pcm_regs.sv */
// Mask, soft reset, manual-state ranking and connection status registers.
// Assumes an I2C slave on ref_clk presents one access per strobe, and that
// the interrupt flags come from the interrupt register on ref_clk.
//
// Overview of operation
// - Writing reset bit one resets logic, registers
// - Disabled bit stays set until host clears
// - Disabled bit overrides port-role changes
// - Port-role change outranks other manual bits
// - First mask: one bit per source
// - Second mask layout, bits 7,4 reserved
// - Masking never stops flag setting
// - Pin releases when no unmasked flag pending
// - Status bit7 weak-battery sink active
// - Status bit6 bus voltage near zero
// - Status bits 5:4 cable orientation
// - Status bit3 bus voltage valid
// - Status bits 2:1 current advertisement
// - Status bit0 attached
// - Global mask blocks pin, resets one
// - One manual bit honoured, priority order
`timescale 1ns/1ns
module pcm_regs (
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              nrst,
   // Register access
   input  wire pcm_pkg::pcm_acc_s acc,
   output logic [7:0]             rdata,
   // Interrupt flags and pin
   input  wire logic [7:0]        flags_a,
   input  wire logic [7:0]        flags_b,
   output logic                   int_n,
   // Port-role register changed this cycle
   input  wire logic              port_role_wr,
   // Detection status inputs, asynchronous
   input  wire pcm_pkg::pcm_conn_s conn_raw,
   // Outputs to the port logic
   output logic                   soft_reset_request,
   output logic                   hold_disabled,
   output pcm_pkg::pcm_req_e      manual_req
);

   logic [7:0]         gate_a;
   logic [7:0]         gate_b;
   logic               global_mask;
   logic               disabled;
   logic [7:0]         next_gate_a;
   logic [7:0]         next_gate_b;
   logic               next_global;
   logic               next_disabled;
   logic               next_srr;
   pcm_pkg::pcm_req_e  next_req;
   pcm_pkg::pcm_conn_s conn_s1;
   pcm_pkg::pcm_conn_s connection_state;
   logic [7:0]         next_rdata;
   logic               next_int_n;
   logic               soft_rst_hit;

   // True when this access writes the given register
   function automatic logic wr_hit(input pcm_pkg::pcm_acc_s a,
                                   input logic [7:0] addr);
      return a.wr && (a.addr == addr);
   endfunction

   // True when some source is pending with its own gate open
   function automatic logic gated_any(input logic [7:0] flags,
                                      input logic [7:0] gate,
                                      input logic [7:0] wmask);
      return |(flags & ~gate & wmask);
   endfunction

   // Host-written one on the reset bit restarts the port logic and the mask, control and manual registers next cycle
   assign soft_rst_hit = wr_hit(acc, pcm_pkg::ADDR_SOFT_RST)
                         && acc.wdata[pcm_pkg::SOFT_RST_BIT];

   always_comb begin
      next_gate_a   = gate_a;
      next_gate_b   = gate_b;
      next_global   = global_mask;
      next_disabled = disabled;
      next_req      = pcm_pkg::PCM_REQ_NONE;
      next_srr      = soft_rst_hit;
      if (wr_hit(acc, pcm_pkg::ADDR_GATE_A)) begin
         next_gate_a = acc.wdata & pcm_pkg::WMASK_GATE_A;
      end
      if (wr_hit(acc, pcm_pkg::ADDR_GATE_B)) begin
         next_gate_b = acc.wdata & pcm_pkg::WMASK_GATE_B;
      end
      if (wr_hit(acc, pcm_pkg::ADDR_CONTROL)) begin
         next_global = acc.wdata[pcm_pkg::GLOBAL_BIT];
      end
      if (wr_hit(acc, pcm_pkg::ADDR_MANUAL)) begin
         // Disabled only changes on an explicit write, never by itself
         next_disabled = acc.wdata[pcm_pkg::MAN_DISABLED];
         // Disabled, role change, err-rec, force src, force snk, unatt src, unatt snk win in that order; the rest are dropped
         if (acc.wdata[pcm_pkg::MAN_DISABLED]) begin
            next_req = pcm_pkg::PCM_REQ_DISABLED;
         end else if (port_role_wr) begin
            next_req = pcm_pkg::PCM_REQ_NONE;
         end else if (acc.wdata[pcm_pkg::MAN_ERR_REC]) begin
            next_req = pcm_pkg::PCM_REQ_ERR_REC;
         end else if (acc.wdata[pcm_pkg::MAN_FORCE_SRC]) begin
            next_req = pcm_pkg::PCM_REQ_FORCE_SRC;
         end else if (acc.wdata[pcm_pkg::MAN_FORCE_SNK]) begin
            next_req = pcm_pkg::PCM_REQ_FORCE_SNK;
         end else if (acc.wdata[pcm_pkg::MAN_UNATT_SRC]) begin
            next_req = pcm_pkg::PCM_REQ_UNATT_SRC;
         end else if (acc.wdata[pcm_pkg::MAN_UNATT_SNK]) begin
            next_req = pcm_pkg::PCM_REQ_UNATT_SNK;
         end
      end
      if (soft_rst_hit) begin
         next_gate_a   = pcm_pkg::RST_GATE;
         next_gate_b   = pcm_pkg::RST_GATE;
         next_global   = pcm_pkg::RST_GLOBAL;
         next_disabled = 1'b0;
         next_req      = pcm_pkg::PCM_REQ_NONE;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         gate_a             <= pcm_pkg::RST_GATE;
         gate_b             <= pcm_pkg::RST_GATE;
         global_mask        <= pcm_pkg::RST_GLOBAL;
         disabled           <= 1'b0;
         manual_req         <= pcm_pkg::PCM_REQ_NONE;
         soft_reset_request <= 1'b0;
      end else begin
         gate_a             <= next_gate_a;
         gate_b             <= next_gate_b;
         global_mask        <= next_global;
         disabled           <= next_disabled;
         manual_req         <= next_req;
         soft_reset_request <= next_srr;
      end
   end

   // Port logic ignores role settings while this is high
   assign hold_disabled = disabled;

   // Status passes two flops; multi-bit fields may show one mixed sample
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         conn_s1          <= pcm_pkg::RST_CONN;
         connection_state <= pcm_pkg::RST_CONN;
      end else begin
         conn_s1          <= conn_raw;
         connection_state <= conn_s1;
      end
   end

   // Flags are never touched here, only gated onto the pin
   always_comb begin
      next_int_n = 1'b1;
      if (!global_mask) begin
         if (gated_any(flags_a, gate_a, pcm_pkg::WMASK_GATE_A)
             || gated_any(flags_b, gate_b, pcm_pkg::WMASK_GATE_B)) begin
            next_int_n = 1'b0;
         end
      end
      case (acc.addr)
         pcm_pkg::ADDR_GATE_A: next_rdata = gate_a;
         pcm_pkg::ADDR_GATE_B: next_rdata = gate_b;
         pcm_pkg::ADDR_CONN:   next_rdata = connection_state;
         pcm_pkg::ADDR_CONTROL:
            next_rdata = {7'h00, global_mask};
         pcm_pkg::ADDR_MANUAL:
            next_rdata = {6'h00, disabled, 1'b0};
         default:              next_rdata = 8'h00;
      endcase
      // Read data holds between strobes so the front end may fetch it late
      if (!acc.rd) begin
         next_rdata = rdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         int_n <= 1'b1;
         rdata <= 8'h00;
      end else begin
         int_n <= next_int_n;
         rdata <= next_rdata;
      end
   end

   a_disabled_sticky: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (disabled && !wr_hit(acc, pcm_pkg::ADDR_MANUAL) && !soft_rst_hit)
      |=> disabled)
      else $error("disabled bit cleared without a write");

   a_disabled_clear: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (wr_hit(acc, pcm_pkg::ADDR_MANUAL)
       && !acc.wdata[pcm_pkg::MAN_DISABLED])
      |=> !hold_disabled)
      else $error("disabled bit not cleared by host write");

   a_hold_follows: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (port_role_wr && hold_disabled && !soft_rst_hit
       && !wr_hit(acc, pcm_pkg::ADDR_MANUAL))
      |=> hold_disabled)
      else $error("port role change lifted the disabled hold");

   a_disabled_first: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (wr_hit(acc, pcm_pkg::ADDR_MANUAL) && !soft_rst_hit
       && acc.wdata[pcm_pkg::MAN_DISABLED])
      |=> (hold_disabled && manual_req == pcm_pkg::PCM_REQ_DISABLED))
      else $error("disabled request not ranked first");

   a_soft_reset: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      soft_rst_hit |=> (soft_reset_request && !hold_disabled
                        && gate_a == pcm_pkg::RST_GATE
                        && gate_b == pcm_pkg::RST_GATE
                        && global_mask == pcm_pkg::RST_GLOBAL))
      else $error("soft reset did not clear registers");

   a_srr_pulse: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      !soft_rst_hit |=> !soft_reset_request)
      else $error("soft reset request without a write");

   a_role_wins: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (wr_hit(acc, pcm_pkg::ADDR_MANUAL) && port_role_wr
       && !acc.wdata[pcm_pkg::MAN_DISABLED] && !soft_rst_hit)
      |=> manual_req == pcm_pkg::PCM_REQ_NONE)
      else $error("manual bit beat port role change");

   a_manual_order: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (wr_hit(acc, pcm_pkg::ADDR_MANUAL) && !port_role_wr && !soft_rst_hit
       && acc.wdata[pcm_pkg::MAN_ERR_REC]
       && !acc.wdata[pcm_pkg::MAN_DISABLED])
      |=> manual_req == pcm_pkg::PCM_REQ_ERR_REC)
      else $error("manual priority wrong");

   a_req_pulse: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      !wr_hit(acc, pcm_pkg::ADDR_MANUAL)
      |=> manual_req == pcm_pkg::PCM_REQ_NONE)
      else $error("manual request outlived its write");

   a_gate_reserved: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      gate_a[7] == 1'b0 && gate_b[7] == 1'b0 && gate_b[4] == 1'b0)
      else $error("reserved mask bit set");

   a_gate_a_write: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (wr_hit(acc, pcm_pkg::ADDR_GATE_A) && !soft_rst_hit)
      |=> gate_a == ($past(acc.wdata) & pcm_pkg::WMASK_GATE_A))
      else $error("first mask write lost");

   a_gate_b_write: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (wr_hit(acc, pcm_pkg::ADDR_GATE_B) && !soft_rst_hit)
      |=> gate_b == ($past(acc.wdata) & pcm_pkg::WMASK_GATE_B))
      else $error("second mask write lost");

   a_global_write: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (wr_hit(acc, pcm_pkg::ADDR_CONTROL) && !soft_rst_hit)
      |=> global_mask == $past(acc.wdata[pcm_pkg::GLOBAL_BIT]))
      else $error("global mask write lost");

   a_pin_global: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      $past(global_mask) |-> int_n)
      else $error("pin asserted under global mask");

   a_pin_asserts: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (!global_mask && |(flags_a & ~gate_a & pcm_pkg::WMASK_GATE_A))
      |=> !int_n)
      else $error("pin not asserted for unmasked flag");

   a_pin_asserts_b: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (!global_mask && |(flags_b & ~gate_b & pcm_pkg::WMASK_GATE_B))
      |=> !int_n)
      else $error("pin not asserted for unmasked second flag");

   a_pin_release: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (!(|(flags_a & ~gate_a & pcm_pkg::WMASK_GATE_A))
       && !(|(flags_b & ~gate_b & pcm_pkg::WMASK_GATE_B)))
      |=> int_n)
      else $error("masked flag held the pin");

   a_conn_read: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (acc.rd && acc.addr == pcm_pkg::ADDR_CONN)
      |=> rdata == $past(connection_state))
      else $error("status read did not return the status");

   a_reserved_read: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (acc.rd && acc.addr == pcm_pkg::ADDR_SOFT_RST)
      |=> rdata == '0)
      else $error("write-only register read back nonzero");

   a_status_path: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      nrst && $past(nrst, 2) |-> connection_state == $past(conn_raw, 2))
      else $error("status not two cycles behind input");

endmodule

/* File: design/pcm_pkg.sv */
// Package for the port control mask and status register bank.
// Assumes an upstream I2C slave turns transfers into byte-wide accesses.
package pcm_pkg;

   // Register offsets
   localparam logic [7:0] ADDR_CONTROL  = 8'h04;
   localparam logic [7:0] ADDR_MANUAL   = 8'h09;
   localparam logic [7:0] ADDR_SOFT_RST = 8'h0A;
   localparam logic [7:0] ADDR_GATE_A   = 8'h0E;
   localparam logic [7:0] ADDR_GATE_B   = 8'h0F;
   localparam logic [7:0] ADDR_CONN     = 8'h11;

   // Reset values and writable-bit masks
   localparam logic [7:0] RST_GATE      = 8'h00;
   localparam logic [7:0] RST_CONN      = 8'h00;
   localparam logic [7:0] WMASK_GATE_A  = 8'h7F;
   localparam logic [7:0] WMASK_GATE_B  = 8'h6F;
   localparam logic       RST_GLOBAL    = 1'b1;

   // Field positions
   localparam int SOFT_RST_BIT   = 0;
   localparam int GLOBAL_BIT     = 0;
   localparam int MAN_ERR_REC    = 0;
   localparam int MAN_DISABLED   = 1;
   localparam int MAN_UNATT_SRC  = 2;
   localparam int MAN_UNATT_SNK  = 3;
   localparam int MAN_FORCE_SNK  = 4;
   localparam int MAN_FORCE_SRC  = 5;
   localparam logic [7:0] MAN_WMASK = 8'h3F;

   // One-hot manual request outcome
   typedef enum logic [6:0] {
      PCM_REQ_NONE      = 7'h01,
      PCM_REQ_DISABLED  = 7'h02,
      PCM_REQ_ERR_REC   = 7'h04,
      PCM_REQ_FORCE_SRC = 7'h08,
      PCM_REQ_FORCE_SNK = 7'h10,
      PCM_REQ_UNATT_SRC = 7'h20,
      PCM_REQ_UNATT_SNK = 7'h40
   } pcm_req_e;

   // Register access from the I2C front end
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pcm_acc_s;

   // Raw connection status from the detection logic
   typedef struct packed {
      logic       weak_battery_sink_active;
      logic       bus_voltage_near_zero;
      logic [1:0] orient;
      logic       bus_voltage_valid;
      logic [1:0] sink_current_level;
      logic       attached;
   } pcm_conn_s;

endpackage

/* File: testbench/pcm_host_model.sv */
// Host model: issues single-byte accesses to the register bank.
// Assumes an I2C slave front end has already turned frames into strobes.
`timescale 1ns/1ns
module pcm_host_model (
   // Clock
   input  wire logic         ref_clk,
   // Register access
   output pcm_pkg::pcm_acc_s acc,
   input  wire logic [7:0]   rdata
);
   initial acc = '0;

   task automatic access(input logic w, input logic [7:0] a, d,
                         output logic [7:0] q);
      @(posedge ref_clk);
      acc <= {w, !w, a, d};
      @(posedge ref_clk);
      // Idle lines carry the inverse so stale values never look live
      acc <= {1'b0, 1'b0, ~a, ~d};
      #1 q = rdata;
   endtask
endmodule

/* File: testbench/pcm_regs_tb.sv */
// Self-checking bench for the mask, status and manual ranking registers.
// Assumes the host model drives all register traffic.
`timescale 1ns/1ns
module pcm_regs_tb;
   logic               ref_clk = 1'b0;
   logic               nrst = 1'b0;
   logic [7:0]         flags_a = 8'h00;
   logic [7:0]         flags_b = 8'h00;
   logic               port_role_wr = 1'b0;
   pcm_pkg::pcm_conn_s conn_raw = '0;
   pcm_pkg::pcm_acc_s  acc;
   pcm_pkg::pcm_req_e  manual_req;
   logic [7:0]         rdata, q, ga, gb;
   logic               int_n, soft_reset_request, hold_disabled;
   int                 fails = 0, total_checks = 0, cycles = 0, i;
   integer             seed = 32'h4BE8;
   logic [7:0]         tv [5] = '{8'h3D, 8'h3C, 8'h1C, 8'h0C, 8'h08};
   logic [7:0]         te [5] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h40};

   pcm_regs dut_u (.ref_clk(ref_clk), .nrst(nrst), .acc(acc),
      .rdata(rdata), .flags_a(flags_a), .flags_b(flags_b), .int_n(int_n),
      .port_role_wr(port_role_wr), .conn_raw(conn_raw),
      .soft_reset_request(soft_reset_request),
      .hold_disabled(hold_disabled), .manual_req(manual_req));
   pcm_host_model host_u (.ref_clk(ref_clk), .acc(acc), .rdata(rdata));

   always #10 ref_clk = ~ref_clk;

   task automatic wrap_up();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // A full run costs far fewer cycles than this ceiling
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         wrap_up();
      end
   end

   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(logic [7:0] a, d);
      host_u.access(1'b1, a, d, q);
   endtask
   task automatic rdc(string n, logic [7:0] a, e);
      host_u.access(1'b0, a, 8'h00, q);
      chk(n, e, q);
   endtask
   function automatic logic [7:0] pin(logic [7:0] fa, fb, ma, mb);
      return {7'h00, !(|(fa & ~ma) || |(fb & ~mb))};
   endfunction

   initial begin
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      rdc("gate_a", pcm_pkg::ADDR_GATE_A, 8'h00);
      rdc("gate_b", pcm_pkg::ADDR_GATE_B, 8'h00);
      rdc("conn", pcm_pkg::ADDR_CONN, 8'h00);
      rdc("control", pcm_pkg::ADDR_CONTROL, 8'h01);
      rdc("soft", pcm_pkg::ADDR_SOFT_RST, 8'h00);
      @(posedge ref_clk) flags_a <= 8'h01;
      @(posedge ref_clk) #1 chk("int_n", 8'h01, {7'h00, int_n});
      wr(pcm_pkg::ADDR_GATE_A, 8'hFF);
      rdc("gate_a", pcm_pkg::ADDR_GATE_A, 8'h7F);
      wr(pcm_pkg::ADDR_GATE_B, 8'hFF);
      rdc("gate_b", pcm_pkg::ADDR_GATE_B, 8'h6F);
      wr(pcm_pkg::ADDR_CONN, 8'hFF);
      wr(8'h33, 8'hFF);
      rdc("conn", pcm_pkg::ADDR_CONN, 8'h00);
      rdc("unmapped", 8'h33, 8'h00);
      wr(pcm_pkg::ADDR_CONTROL, 8'h00);
      // First pass: every flag pending but masked must leave the pin high
      for (i = 0; i < 24; i++) begin
         ga = (i == 0) ? 8'h7F : 8'($random(seed)) & 8'h7F;
         gb = (i == 0) ? 8'h6F : 8'($random(seed)) & 8'h6F;
         wr(pcm_pkg::ADDR_GATE_A, ga);
         wr(pcm_pkg::ADDR_GATE_B, gb);
         @(posedge ref_clk);
         flags_a <= (i == 0) ? 8'h7F : 8'($random(seed)) & 8'h7F;
         flags_b <= (i == 0) ? 8'h6F : 8'($random(seed)) & 8'h6F;
         conn_raw <= 8'($random(seed));
         @(posedge ref_clk) #1;
         chk("int_n", pin(flags_a, flags_b, ga, gb),
             {7'h00, int_n});
         rdc("conn", pcm_pkg::ADDR_CONN,
             conn_raw);
      end
      wr(pcm_pkg::ADDR_MANUAL, 8'h3F);
      chk("manual_req", 8'h02, {1'b0, manual_req});
      @(posedge ref_clk) port_role_wr <= 1'b1;
      @(posedge ref_clk) port_role_wr <= 1'b0;
      @(posedge ref_clk) #1 chk("hold", 8'h01, {7'h00, hold_disabled});
      rdc("manual", pcm_pkg::ADDR_MANUAL, 8'h02);
      wr(pcm_pkg::ADDR_MANUAL, 8'h00);
      chk("hold", 8'h00, {7'h00, hold_disabled});
      for (i = 0; i < 5; i++) begin
         wr(pcm_pkg::ADDR_MANUAL, tv[i]);
         chk("manual_req", te[i], {1'b0, manual_req});
      end
      fork
         wr(pcm_pkg::ADDR_MANUAL, 8'h01);
         begin
            @(posedge ref_clk) port_role_wr <= 1'b1;
            @(posedge ref_clk) port_role_wr <= 1'b0;
         end
      join
      chk("manual_req", 8'h01, {1'b0, manual_req});
      wr(pcm_pkg::ADDR_GATE_A, 8'h55);
      wr(pcm_pkg::ADDR_MANUAL, 8'h02);
      wr(pcm_pkg::ADDR_SOFT_RST, 8'hFE);
      chk("soft_req", 8'h00, {7'h00, soft_reset_request});
      rdc("gate_a", pcm_pkg::ADDR_GATE_A, 8'h55);
      wr(pcm_pkg::ADDR_SOFT_RST, 8'h01);
      chk("soft_req", 8'h01, {7'h00, soft_reset_request});
      rdc("gate_a", pcm_pkg::ADDR_GATE_A, 8'h00);
      rdc("control", pcm_pkg::ADDR_CONTROL, 8'h01);
      rdc("manual", pcm_pkg::ADDR_MANUAL, 8'h00);
      chk("hold", 8'h00, {7'h00, hold_disabled});
      wrap_up();
   end
endmodule
